// file: logic/sre_pkg.sv
// sre_pkg: constants and carrier types for the recoverable error reporting block
// assumes: one 250 MHz clock, word-aligned 32-bit register access

package sre_pkg;

  // ---------------------------------------------------------------------
  // bank status word bit positions (64-bit record)
  // ---------------------------------------------------------------------
  localparam int SRE_VAL_BIT = 63;
  localparam int SRE_OVER_BIT = 62;
  localparam int SRE_UC_BIT = 61;
  localparam int SRE_EN_BIT = 60;
  localparam int SRE_EXTRA_INFO_VALID_BIT = 59;
  localparam int SRE_FAULT_LOCATION_VALID_BIT = 58;
  localparam int SRE_PCC_BIT = 57;
  localparam int SRE_S_BIT = 56;
  localparam int SRE_AR_BIT = 55;
  localparam int SRE_FILT_BIT = 12;

  // ---------------------------------------------------------------------
  // compound error code subfields
  // ---------------------------------------------------------------------
  localparam logic [3:0] SRE_CLASS_CACHE = 4'h1;
  localparam logic [3:0] SRE_REQ_LOAD = 4'h3;
  localparam logic [3:0] SRE_REQ_FETCH = 4'h5;
  localparam logic [1:0] SRE_TT_DATA = 2'h1;
  localparam logic [1:0] SRE_TT_INSN = 2'h0;
  localparam logic [1:0] SRE_LVL_ZERO = 2'h0;
  localparam logic SRE_FILT_NORMAL = 1'h0;
  localparam logic [15:0] SRE_CODE_LOAD = 16'h0134;
  localparam logic [15:0] SRE_CODE_FETCH = 16'h0150;
  localparam logic [2:0] SRE_MODE_PHYS = 3'h2;

  // ---------------------------------------------------------------------
  // register map (pages, word field indices, control byte address, global bits, reset values)
  // ---------------------------------------------------------------------
  localparam logic [3:0] SRE_BANK_PAGE = 4'h0;
  localparam logic [3:0] SRE_GLOB_PAGE = 4'h1;
  localparam logic [11:0] SRE_CTRL_ADR = 12'h200;
  localparam logic [2:0] SRE_F_STAT_LO = 3'h0;
  localparam logic [2:0] SRE_F_STAT_HI = 3'h1;
  localparam logic [2:0] SRE_F_ADDR_LO = 3'h2;
  localparam logic [2:0] SRE_F_ADDR_HI = 3'h3;
  localparam logic [2:0] SRE_F_MISC = 3'h4;
  localparam int SRE_G_RESTART_POINTER_VALID = 0;
  localparam int SRE_G_ERROR_POINTER_VALID = 1;
  localparam int SRE_G_MCIP = 2;
  localparam logic SRE_EN_RST = 1'h1;
  localparam logic [7:0] SRE_WIN_RST = 8'h10;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic {SRE_KIND_LOAD, SRE_KIND_FETCH} sre_kind_t;

  typedef struct packed {
    sre_kind_t kind;
    logic [3:0] lp;
    logic [3:0] bank;
    logic [47:0] addr;
    logic [5:0] lsb;
  } sre_err_t;

  typedef struct packed {
    logic [63:0] status;
    logic [47:0] addr;
    logic [8:0] misc;
  } sre_bank_t;

  typedef struct packed {
    logic mcip;
    logic error_pointer_valid;
    logic restart_pointer_valid;
  } sre_glob_t;

endpackage

// file: logic/sre_code_gen.sv
// sre_code_gen: compound error code and affected-processor pointer flag per error kind
// assumes: kind is stable while sampled by the caller

`timescale 1ns/1ns

module sre_code_gen
  import sre_pkg::*;
(
  input wire sre_kind_t kind_i, // kind of consumed bad data
  output logic [15:0] code_o, // compound error code
  output logic error_pointer_valid_o // error pointer flag for the affected processor
);

  always_comb begin
    code_o = '0;
    code_o[SRE_FILT_BIT] = SRE_FILT_NORMAL;
    code_o[11:8] = SRE_CLASS_CACHE;
    code_o[1:0] = SRE_LVL_ZERO;
    if (kind_i == SRE_KIND_LOAD) begin
      code_o[7:4] = SRE_REQ_LOAD;
      code_o[3:2] = SRE_TT_DATA;
      error_pointer_valid_o = 1'b1;
    end else begin
      code_o[7:4] = SRE_REQ_FETCH;
      code_o[3:2] = SRE_TT_INSN;
      error_pointer_valid_o = 1'b0;
    end
  end

endmodule

// file: logic/sre_window.sv
// sre_window: detection window that gathers errors into one broadcast event
// assumes: err_i is a one-cycle pulse per accepted error

`timescale 1ns/1ns

module sre_window
  import sre_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset, active high
  input wire logic err_i, // accepted error pulse
  input wire logic [7:0] len_i, // extra cycles the window stays open
  output logic open_o, // window open
  output logic fire_o // last window cycle, broadcast now
);

  typedef enum logic {SRE_W_IDLE, SRE_W_OPEN} sre_wst_t;
  typedef struct packed {
    sre_wst_t st;
    logic [7:0] cnt;
  } sre_wstate_t;

  sre_wstate_t q;
  sre_wstate_t d;

  always_comb begin
    d = q;
    case (q.st)
      SRE_W_IDLE: begin
        if (err_i) begin
          d.st = SRE_W_OPEN;
          d.cnt = len_i;
        end
      end
      SRE_W_OPEN: begin
        if (q.cnt == 8'h00) begin
          d.st = SRE_W_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: d.st = SRE_W_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: SRE_W_IDLE, cnt: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign open_o = (q.st == SRE_W_OPEN);
  assign fire_o = (q.st == SRE_W_OPEN) && (q.cnt == 8'h00);

endmodule

// file: logic/sre_report.sv
// sre_report: logs recoverable action-required errors into banks and broadcasts the check
// assumes: classic Wishbone slave, errors arrive as one-cycle pulses with a record
//
// Operation
// - data-load error logs compound code 0x134, request subfield data load
// - data-load error sets transaction type subfield to data
// - instruction-fetch error logs compound code 0x150, request subfield fetch
// - instruction-fetch error sets transaction type subfield to instruction
// - both errors use cache level zero
// - both errors keep the filtering bit at zero
// - logging sets valid, uncorrected, enabled, signalled, action-required
// - logging sets fault-location-valid and extra-info-valid
// - extra info holds physical address mode and lowest valid address bit
// - machine check is broadcast to every logical processor
// - global status tells software which processor is affected
// - affected processor is the consumer; the bank named in the error record holds it
// - data load: affected processor restart flag clear, error pointer set
// - instruction fetch: affected processor clears both pointer flags
// - observing, unaffected processors set restart flag, clear error pointer
// - errors in one detection window merge into one broadcast
// - merged errors: each processor's global flags reflect the most severe error it consumed

`timescale 1ns/1ns

module sre_report
  import sre_pkg::*;
#(
  parameter int NLP = 4,
  parameter int NBANK = 4
) (
  input wire logic clk_i, // clock, 250 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte lanes
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic err_valid_i, // error detected, one-cycle pulse
  input wire sre_err_t err_i, // error record
  output logic [NLP-1:0] mce_o, // machine check broadcast pulse
  output logic win_open_o // detection window open
);

  // ---------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------
  if (NLP < 2 || NLP > 16 || NBANK < 2 || NBANK > 8) begin : g_bad
    $error("sre_report: NLP must be 2..16 and NBANK 2..8");
  end

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    sre_bank_t [NBANK-1:0] bank;
    sre_glob_t [NLP-1:0] glob;
    logic [NLP-1:0] hit;
    logic [NLP-1:0] error_pointer_valid_p;
    logic en;
    logic [7:0] win;
    logic ack;
    logic [31:0] dat;
    logic [NLP-1:0] machine_check_broadcast;
  } sre_state_t;

  sre_state_t q;
  sre_state_t d;

  logic acc;
  logic [15:0] code;
  logic aff_error_pointer_valid;
  logic win_fire;

  function automatic logic [31:0] sre_merge(input logic [31:0] o, input logic [31:0] w,
                                            input logic [3:0] s);
    sre_merge = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        sre_merge[8*k +: 8] = w[8*k +: 8];
      end
    end
  endfunction

  assign acc = err_valid_i && q.en && (int'(err_i.bank) < NBANK) && (int'(err_i.lp) < NLP);

  sre_code_gen u_code (
    .kind_i(err_i.kind),
    .code_o(code),
    .error_pointer_valid_o(aff_error_pointer_valid)
  );

  sre_window u_win (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .err_i(acc),
    .len_i(q.win),
    .open_o(win_open_o),
    .fire_o(win_fire)
  );

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [63:0] st;
    logic [2:0] fld;
    int bi;
    int li;
    logic req;
    logic wr;
    logic [31:0] rd;
    st = '0;
    fld = wb_adr_i[4:2];
    bi = int'(wb_adr_i[7:5]);
    li = int'(wb_adr_i[5:2]);
    req = wb_cyc_i && wb_stb_i;
    wr = req && wb_we_i && q.ack;
    rd = '0;
    d = q;
    d.machine_check_broadcast = '0;
    d.ack = req && !q.ack;

    // bus decode: reads sampled when ack is raised, writes on the ack edge
    if (wb_adr_i[11:8] == SRE_BANK_PAGE && bi < NBANK) begin
      if (fld == SRE_F_STAT_LO) begin
        rd = q.bank[bi].status[31:0];
        if (wr) d.bank[bi].status[31:0] = sre_merge(q.bank[bi].status[31:0], wb_dat_i, wb_sel_i);
      end else if (fld == SRE_F_STAT_HI) begin
        rd = q.bank[bi].status[63:32];
        if (wr) d.bank[bi].status[63:32] = sre_merge(q.bank[bi].status[63:32], wb_dat_i, wb_sel_i);
      end else if (fld == SRE_F_ADDR_LO) begin
        rd = q.bank[bi].addr[31:0];
      end else if (fld == SRE_F_ADDR_HI) begin
        rd = {16'h0000, q.bank[bi].addr[47:32]};
      end else if (fld == SRE_F_MISC) begin
        rd = {23'h000000, q.bank[bi].misc};
      end
    end else if (wb_adr_i[11:8] == SRE_GLOB_PAGE && wb_adr_i[7:6] == 2'h0 && li < NLP) begin
      rd = {29'h00000000, q.glob[li]};
      if (wr && wb_sel_i[0]) begin
        // only the in-progress flag is software clearable
        d.glob[li].mcip = q.glob[li].mcip & wb_dat_i[SRE_G_MCIP];
      end
    end else if (wb_adr_i == SRE_CTRL_ADR) begin
      rd = {16'h0000, q.win, 7'h00, q.en};
      if (wr) begin
        if (wb_sel_i[0]) d.en = wb_dat_i[0];
        if (wb_sel_i[1]) d.win = wb_dat_i[15:8];
      end
    end
    if (req && !q.ack) d.dat = rd;

    // hardware logging after software writes so a new record wins over a clear
    if (acc) begin
      st[SRE_VAL_BIT] = 1'b1;
      st[SRE_UC_BIT] = 1'b1;
      st[SRE_EN_BIT] = 1'b1;
      st[SRE_S_BIT] = 1'b1;
      st[SRE_AR_BIT] = 1'b1;
      st[SRE_PCC_BIT] = 1'b0;
      st[SRE_EXTRA_INFO_VALID_BIT] = 1'b1;
      st[SRE_FAULT_LOCATION_VALID_BIT] = 1'b1;
      // an earlier record whose valid bit is still set makes this one an overflow
      st[SRE_OVER_BIT] = q.bank[int'(err_i.bank)].status[SRE_VAL_BIT];
      st[15:0] = code;
      d.bank[int'(err_i.bank)].status = st;
      d.bank[int'(err_i.bank)].addr = err_i.addr;
      d.bank[int'(err_i.bank)].misc = {SRE_MODE_PHYS, err_i.lsb};
      // fetch outranks load: error pointer stays set only if all hits were loads
      if (q.hit[int'(err_i.lp)]) begin
        d.error_pointer_valid_p[int'(err_i.lp)] = q.error_pointer_valid_p[int'(err_i.lp)] & aff_error_pointer_valid;
      end else begin
        d.error_pointer_valid_p[int'(err_i.lp)] = aff_error_pointer_valid;
      end
      d.hit[int'(err_i.lp)] = 1'b1;
    end

    // end of window: one broadcast for all gathered errors
    if (win_fire) begin
      for (int i = 0; i < NLP; i++) begin
        d.glob[i].restart_pointer_valid = !d.hit[i];
        d.glob[i].error_pointer_valid = d.hit[i] & d.error_pointer_valid_p[i];
        d.glob[i].mcip = 1'b1;
      end
      d.hit = '0;
      d.error_pointer_valid_p = '0;
      d.machine_check_broadcast = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.en <= SRE_EN_RST;
      q.win <= SRE_WIN_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign mce_o = q.machine_check_broadcast;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic b0;
  logic l0;
  assign b0 = acc && err_i.bank == 4'h0;
  assign l0 = acc && err_i.lp == 4'h0;

  // ---------------------------------------------------------------------
  // assertion helpers: which kinds processor 0 consumed in the open window
  // ---------------------------------------------------------------------
  logic ld0_now;
  logic fe0_now;
  logic ld0_seen;
  logic fe0_seen;
  logic ld0_any;
  logic fe0_any;
  assign ld0_now = l0 && err_i.kind == SRE_KIND_LOAD;
  assign fe0_now = l0 && err_i.kind == SRE_KIND_FETCH;
  assign ld0_any = ld0_now || ld0_seen;
  assign fe0_any = fe0_now || fe0_seen;

  // forgets at each broadcast, so every window is judged on its own errors
  always_ff @(posedge clk_i) begin
    if (rst_i || win_fire) begin
      ld0_seen <= 1'b0;
      fe0_seen <= 1'b0;
    end else begin
      ld0_seen <= ld0_any;
      fe0_seen <= fe0_any;
    end
  end

  property p_load_code;
    b0 && err_i.kind == SRE_KIND_LOAD |=> q.bank[0].status[15:0] == 16'h0134;
  endproperty
  a_load_code: assert property (p_load_code) else $error("load code wrong");

  property p_load_tt;
    b0 && err_i.kind == SRE_KIND_LOAD |=> q.bank[0].status[3:2] == 2'h1;
  endproperty
  a_load_tt: assert property (p_load_tt) else $error("load transaction type wrong");

  property p_fetch_code;
    b0 && err_i.kind == SRE_KIND_FETCH |=> q.bank[0].status[15:0] == 16'h0150;
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("fetch code wrong");

  property p_fetch_tt;
    b0 && err_i.kind == SRE_KIND_FETCH |=> q.bank[0].status[3:2] == 2'h0;
  endproperty
  a_fetch_tt: assert property (p_fetch_tt) else $error("fetch transaction type wrong");

  property p_level;
    b0 |=> q.bank[0].status[1:0] == 2'h0;
  endproperty
  a_level: assert property (p_level) else $error("cache level not zero");

  property p_filter;
    b0 |=> !q.bank[0].status[12];
  endproperty
  a_filter: assert property (p_filter) else $error("filter bit set");

  property p_flags;
    b0 |=> q.bank[0].status[63] && q.bank[0].status[61] && q.bank[0].status[60]
           && q.bank[0].status[56] && q.bank[0].status[55] && !q.bank[0].status[57];
  endproperty
  a_flags: assert property (p_flags) else $error("status flags wrong");

  property p_loc;
    b0 |=> q.bank[0].status[59:58] == 2'h3 && q.bank[0].misc[8:6] == 3'h2
           && q.bank[0].addr == $past(err_i.addr);
  endproperty
  a_loc: assert property (p_loc) else $error("location info wrong");

  property p_bcast;
    acc |-> ##[1:258] mce_o == '1;
  endproperty
  a_bcast: assert property (p_bcast) else $error("no broadcast after error");

  property p_load_aff;
    win_fire && ld0_any && !fe0_any |=> !q.glob[0].restart_pointer_valid && q.glob[0].error_pointer_valid;
  endproperty
  a_load_aff: assert property (p_load_aff) else $error("load pointer flags wrong");

  property p_fetch_aff;
    win_fire && fe0_any |=> !q.glob[0].restart_pointer_valid && !q.glob[0].error_pointer_valid;
  endproperty
  a_fetch_aff: assert property (p_fetch_aff) else $error("fetch pointer flags wrong");

  property p_observer;
    win_fire && !ld0_any && !fe0_any |=> q.glob[0].restart_pointer_valid && !q.glob[0].error_pointer_valid && mce_o[0];
  endproperty
  a_observer: assert property (p_observer) else $error("observer flags wrong");

  property p_misc;
    b0 |=> q.bank[0].misc[5:0] == $past(err_i.lsb) && q.bank[0].misc[8:6] == 3'h2;
  endproperty
  a_misc: assert property (p_misc) else $error("extra info wrong");

  property p_code_place;
    b0 |=> q.bank[0].status[15:13] == 3'h0 && q.bank[0].status[11:8] == 4'h1;
  endproperty
  a_code_place: assert property (p_code_place) else $error("code field wrong");

  property p_over;
    b0 && q.bank[0].status[63] |=> q.bank[0].status[62];
  endproperty
  a_over: assert property (p_over) else $error("overflow not flagged");

  property p_pulse;
    mce_o[0] |=> !mce_o[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("broadcast longer than one cycle");

  property p_all;
    mce_o != '0 |-> mce_o == '1;
  endproperty
  a_all: assert property (p_all) else $error("broadcast not to every processor");

  property p_quiet;
    !win_open_o |=> mce_o == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("broadcast without window");

  c_load: cover property (b0 && err_i.kind == SRE_KIND_LOAD ##[1:300] mce_o[0]);
  c_fetch: cover property (l0 && err_i.kind == SRE_KIND_FETCH ##[1:300] mce_o[0]);
  c_merge: cover property (acc ##[1:8] (win_open_o && acc) ##[1:300] mce_o[0]);
  c_over: cover property (b0 && q.bank[0].status[63]);
  c_observer: cover property (win_fire && !ld0_any && !fe0_any);

endmodule

// file: tb/sre_report_test.sv
// sre_report_test: self-checking bench for the recoverable error reporting block
// assumes: one 250 MHz clock, classic Wishbone single cycles, window length set to 2

`timescale 1ns/1ns

module sre_report_test;
  import sre_pkg::*;

  localparam int NLP = 4;
  localparam int NBANK = 4;
  localparam int WIN = 2;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic err_valid_i = 1'b0;
  sre_err_t err_i = '0;
  logic [NLP-1:0] mce_o;
  logic win_open_o;
  int n_fail = 0;
  int n_tests = 0;
  int n_mce = 0;
  logic [31:0] rd;

  sre_report #(.NLP(NLP), .NBANK(NBANK)) u_sre_report (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .err_valid_i(err_valid_i), .err_i(err_i),
    .mce_o(mce_o), .win_open_o(win_open_o)
  );

  // ---------------------------------------------------------------
  // clock, pulse counter, watchdog
  // ---------------------------------------------------------------
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (mce_o === {NLP{1'b1}}) n_mce <= n_mce + 1;
  end

  initial begin
    #80000;
    n_fail = n_fail + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // classic single cycle; request held until the edge that samples ack high
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (wb_ack_o !== 1'b1) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: no acknowledge", $time);
    end
    @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wb_read_chk(input logic [11:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000);
    chk(rd, exp, "register read");
  endtask

  task automatic send_err(input sre_kind_t kind, input logic [3:0] lp, input logic [3:0] bank);
    @(posedge clk_i);
    err_valid_i <= 1'b1;
    err_i.kind <= kind;
    err_i.lp <= lp;
    err_i.bank <= bank;
    err_i.addr <= 48'h1234_5678_9000 + {44'h0, bank};
    err_i.lsb <= 6'h0c;
    @(posedge clk_i);
    err_valid_i <= 1'b0;
  endtask

  // counts from the first cycle after the taking edge until the broadcast shows
  task automatic wait_mce(output int n);
    n = 1;
    #1;
    while (mce_o !== {NLP{1'b1}} && n < 50) begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    int n;
    int base;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;

    wb_read_chk(12'h200, 32'h0000_1001);
    wb_read_chk(12'h100, 32'h0000_0000);
    wb_read_chk(12'h004, 32'h0000_0000);
    wb_xfer(1'b1, 12'h300, 32'hffff_ffff);
    wb_read_chk(12'h300, 32'h0000_0000);
    wb_xfer(1'b1, 12'h200, {16'h0, 8'(WIN), 8'h01});
    $display("test reset_and_map done");

    send_err(SRE_KIND_LOAD, 4'h1, 4'h0);
    #1;
    chk(32'(win_open_o), 32'h0000_0001, "window open");
    wait_mce(n);
    chk(n, 2 + WIN, "broadcast latency");
    wb_read_chk(12'h000, 32'h0000_0134);
    wb_read_chk(12'h004, 32'hbd80_0000);
    wb_read_chk(12'h008, 32'h5678_9000);
    wb_read_chk(12'h00c, 32'h0000_1234);
    wb_read_chk(12'h010, 32'h0000_008c);
    for (int i = 0; i < NLP; i++) begin
      wb_read_chk(12'h100 + 12'(i * 4), (i == 1) ? 32'h6 : 32'h5);
    end
    $display("test load_error done");

    send_err(SRE_KIND_FETCH, 4'h2, 4'h1);
    wait_mce(n);
    chk(n, 2 + WIN, "broadcast latency");
    wb_read_chk(12'h020, 32'h0000_0150);
    wb_read_chk(12'h024, 32'hbd80_0000);
    for (int i = 0; i < NLP; i++) begin
      wb_read_chk(12'h100 + 12'(i * 4), (i == 2) ? 32'h4 : 32'h5);
    end
    wb_xfer(1'b1, 12'h100, 32'h0000_0000);
    wb_read_chk(12'h100, 32'h0000_0001);
    $display("test fetch_error done");

    repeat (4) @(posedge clk_i);
    base = n_mce;
    send_err(SRE_KIND_LOAD, 4'h0, 4'h2);
    send_err(SRE_KIND_FETCH, 4'h0, 4'h3);
    repeat (WIN + 8) @(posedge clk_i);
    chk(n_mce - base, 1, "merged broadcast count");
    wb_read_chk(12'h040, 32'h0000_0134);
    wb_read_chk(12'h060, 32'h0000_0150);
    wb_read_chk(12'h100, 32'h0000_0004);
    wb_read_chk(12'h104, 32'h0000_0005);
    $display("test merge done");

    send_err(SRE_KIND_LOAD, 4'h0, 4'h0);
    repeat (WIN + 8) @(posedge clk_i);
    wb_read_chk(12'h004, 32'hfd80_0000);
    wb_read_chk(12'h100, 32'h0000_0006);
    wb_read_chk(12'h10c, 32'h0000_0005);
    wb_xfer(1'b1, 12'h024, 32'h0000_0000);
    wb_read_chk(12'h024, 32'h0000_0000);
    $display("test overwrite_and_clear done");

    wb_xfer(1'b1, 12'h200, {16'h0, 8'(WIN), 8'h00});
    base = n_mce;
    send_err(SRE_KIND_FETCH, 4'h0, 4'h1);
    repeat (WIN + 8) @(posedge clk_i);
    chk(n_mce - base, 0, "broadcast while disabled");
    wb_read_chk(12'h024, 32'h0000_0000);
    wb_xfer(1'b1, 12'h200, {16'h0, 8'(WIN), 8'h01});
    send_err(SRE_KIND_FETCH, 4'h0, 4'(NBANK));
    repeat (WIN + 8) @(posedge clk_i);
    chk(n_mce - base, 0, "broadcast for absent bank");
    $display("test refused_errors done");

    complete_run();
  end

endmodule
